// [rtl/conv_ctrl_pkg.sv]
// package: constants for the sampling converter control block
package conv_ctrl_pkg;
  localparam int          CLK_HZ            = 40_000_000;
  localparam int          MIN_LOW_NS        = 40;
  localparam int          MIN_LOW_CYC       = (MIN_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int          CONV_TIME_NS      = 20_000;
  localparam int          CONV_CYC          = (CONV_TIME_NS / 1000) * (CLK_HZ / 1_000_000);
  localparam int          SHIFT_HALF_CYC    = 4;
  localparam int          RESULT_BITS       = 16;
  localparam int          BYTE_BITS         = 8;
  localparam logic [15:0] RESULT_RESET      = 16'h0000;
  localparam logic [15:0] SIGN_FLIP         = 16'h8000;
  localparam logic [15:0] SAMPLE_RESET      = 16'h0000;
  localparam int          SAMPLE_BITS       = 16;
  localparam logic [11:0] ADDR_SAMPLE       = 12'h000;
  localparam logic [11:0] ADDR_RESULT       = 12'h004;
  localparam logic [11:0] ADDR_STATUS       = 12'h008;
  localparam logic [1:0]  RESP_OKAY         = 2'b00;
  localparam logic [1:0]  RESP_SLVERR       = 2'b10;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } conv_state_t;
endpackage

// [rtl/sar_adc_conversion_control.sv]
// sar_adc_conversion_control: convert start, busy, parallel and serial result output
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: host holds read/convert low between 40 ns and 12 us to start.
// RULE2: busy low from start until conversion done and output register loaded.
// RULE3: half-select low gives upper byte, high gives lower byte.
// RULE4: toggling half-select presents the other half of the same result.
// RULE5: while busy is low, further convert commands are ignored.
// RULE6: host should space convert commands at least 25 us apart.
// RULE7: internal-clock serial mode shifts previous result with exactly 16 pulses.
// RULE8: in serial internal mode busy waits for conversion and transfer both.
// RULE9: serial bits msb first, stable across both shift clock edges.
// RULE10: select and read/convert both low for 40 ns starts conversion.
// RULE11: host raises select or read/convert before busy rises, else invalid reconvert.
// RULE12: select high keeps parallel bus released and does nothing.
// RULE13: conversion start releases or keeps released the parallel bus.
// RULE14: select low, read/convert high, busy high drives latest result.
// RULE15: read during conversion returns previous result.
// RULE16: inputs ored, level triggered; host sets other input 10 ns earlier.
// RULE17: clock-source select low at start outputs previous result serially.
// RULE18: internal mode clocks serial out every cycle regardless of select.
// RULE19: select tied low, parallel output responds when read/convert goes high.
// RULE20: clock-source low makes shift clock an output of 16 pulses, else input.
// RULE21: format-select high straight binary, low two's complement.
// RULE22: conversion and shift rates counted in internal clock cycles.
// RULE23: output register loaded in one step at end of conversion.
module sar_adc_conversion_control
  import conv_ctrl_pkg::*;
#(
  parameter int conv_cycles   = CONV_CYC,
  parameter int shift_half    = SHIFT_HALF_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        select_n,
  input  wire logic        read_convert,
  input  wire logic        half_select,
  input  wire logic        clock_source_select,
  input  wire logic        format_select,
  output logic             busy_n,
  output logic [7:0]       parallel_bus,
  output logic             parallel_bus_oe,
  output logic             serial_result_out,
  output logic             shift_clock,
  output logic             shift_clock_oe,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam int CW = $clog2(conv_cycles + 2) + 1;

  logic [1:0]  cs_sync_r;
  logic [1:0]  rc_sync_r;
  logic [1:0]  hs_sync_r;
  logic [1:0]  src_sync_r;
  logic [1:0]  fmt_sync_r;
  logic        cs_q;
  logic        rc_q;
  logic [3:0]  low_cnt_r;
  logic        next_bit;
  conv_state_t state_r;
  logic [CW-1:0] conv_cnt_r;
  logic        conv_done_r;
  logic [15:0] result_r;
  logic [15:0] sample_r;
  logic [15:0] shift_r;
  logic [4:0]  bits_left_r;
  logic [7:0]  half_cnt_r;
  logic        serial_active_r;
  logic        start;
  logic        aw_got_r;
  logic        w_got_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;

  function automatic logic [15:0] encode(input logic [15:0] raw, input logic sb);
    encode = sb ? (raw ^ SIGN_FLIP) : raw; // RULE21
  endfunction

  // pins cross into aclk through two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_sync_r  <= 2'h3;
      rc_sync_r  <= 2'h3;
      hs_sync_r  <= 2'h0;
      src_sync_r <= 2'h3;
      fmt_sync_r <= 2'h0;
    end else begin
      cs_sync_r  <= {cs_sync_r[0], select_n};
      rc_sync_r  <= {rc_sync_r[0], read_convert};
      hs_sync_r  <= {hs_sync_r[0], half_select};
      src_sync_r <= {src_sync_r[0], clock_source_select};
      fmt_sync_r <= {fmt_sync_r[0], format_select};
    end
  end
  assign cs_q = cs_sync_r[1];
  assign rc_q = rc_sync_r[1];

  // ored level detect, needs MIN_LOW_CYC cycles of both low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_r <= 4'h0;
    end else if (cs_q | rc_q) begin // RULE16
      low_cnt_r <= 4'h0;
    end else if (low_cnt_r < 4'(MIN_LOW_CYC)) begin
      low_cnt_r <= low_cnt_r + 4'h1;
    end
  end
  // level triggered: still low at busy rise re-arms a start (invalid sample)
  assign start = (state_r == ST_IDLE) && (low_cnt_r >= 4'(MIN_LOW_CYC)); // RULE10 RULE1 RULE11

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= ST_IDLE;
      conv_cnt_r <= '0;
      conv_done_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          conv_done_r <= 1'b0;
          if (start) begin // RULE5
            state_r    <= ST_CONV;
            conv_cnt_r <= '0;
          end
        end
        ST_CONV: begin
          if (conv_cnt_r >= CW'(conv_cycles - 1)) begin // RULE22
            conv_done_r <= 1'b1;
            // serial mode: stay here until the last pulse is out
            if (!serial_active_r) state_r <= ST_DONE; // RULE8
          end else begin
            conv_cnt_r <= conv_cnt_r + 1'b1;
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // busy low through conversion; high on the ST_DONE edge, at least one cycle after the result lands
  always_ff @(posedge aclk) begin
    if (!aresetn) busy_n <= 1'b1;
    else if (start) busy_n <= 1'b0; // RULE2 RULE13
    else if (state_r == ST_DONE) busy_n <= 1'b1;
  end

  // one-step update; sample source is software-written code
  always_ff @(posedge aclk) begin
    if (!aresetn) result_r <= RESULT_RESET;
    else if (state_r == ST_CONV && conv_done_r == 1'b0 &&
             conv_cnt_r >= CW'(conv_cycles - 1))
      result_r <= encode(sample_r, fmt_sync_r[1]); // RULE23 RULE15
  end

  // parallel bus: registered, select high releases it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      parallel_bus    <= 8'h00;
      parallel_bus_oe <= 1'b0;
    end else begin
      parallel_bus_oe <= !cs_q && rc_q && !start; // RULE12 RULE14 RULE19 RULE13
      parallel_bus    <= hs_sync_r[1] ? result_r[7:0] : result_r[15:8]; // RULE3 RULE4
    end
  end

  // pulse timing of the serial port, internal clock mode only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bits_left_r       <= 5'h00;
      half_cnt_r        <= 8'h00;
      serial_active_r   <= 1'b0;
      shift_clock       <= 1'b0;
    end else if (start && !src_sync_r[1]) begin // RULE17 RULE18
      bits_left_r       <= 5'(RESULT_BITS);
      half_cnt_r        <= 8'h00;
      serial_active_r   <= 1'b1;
      shift_clock       <= 1'b0;
    end else if (serial_active_r) begin
      if (half_cnt_r >= 8'(shift_half - 1)) begin // RULE22
        half_cnt_r <= 8'h00;
        if (!shift_clock) begin
          shift_clock <= 1'b1;
        end else begin
          shift_clock <= 1'b0; // RULE7
          bits_left_r <= bits_left_r - 5'h01;
          if (bits_left_r == 5'h01) serial_active_r <= 1'b0;
        end
      end else begin
        half_cnt_r <= half_cnt_r + 8'h01;
      end
    end
  end

  // data moves in the cycle after a falling edge, never on an edge
  // limitation: shift_half below 2 would put that cycle on a rising edge
  assign next_bit = serial_active_r && !shift_clock && (half_cnt_r == 8'h00) &&
                    (bits_left_r != 5'(RESULT_BITS));

  // serial data path, loaded with the previous result at each start in internal clock mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_r           <= 16'h0000;
      serial_result_out <= 1'b0;
    end else if (start && !src_sync_r[1]) begin // RULE17
      shift_r           <= result_r;
      serial_result_out <= result_r[15]; // RULE9
    end else if (next_bit) begin // RULE9
      shift_r           <= {shift_r[14:0], 1'b0};
      serial_result_out <= shift_r[14];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) shift_clock_oe <= 1'b0;
    else shift_clock_oe <= !src_sync_r[1]; // RULE20
  end

  // axi4-lite write: address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 12'h000;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      sample_r      <= SAMPLE_RESET;
    end else begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
      s_axi_wready  <= !w_got_r && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (aw_got_r && w_got_r && !s_axi_bvalid) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_r[11:2] == ADDR_SAMPLE[11:2]) begin
          s_axi_bresp <= RESP_OKAY;
          if (w_strb_r[0]) sample_r[7:0]  <= w_data_r[7:0];
          if (w_strb_r[1]) sample_r[15:8] <= w_data_r[15:8];
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case (s_axi_araddr[11:2])
          ADDR_SAMPLE[11:2]: s_axi_rdata <= {16'h0000, sample_r};
          ADDR_RESULT[11:2]: s_axi_rdata <= {16'h0000, result_r};
          ADDR_STATUS[11:2]: s_axi_rdata <= {29'h0, serial_active_r, !busy_n, busy_n};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // sar_adc_conversion_control

// [verif/conv_ctrl_sva.sv]
// checker: port-level properties of the conversion control block
`timescale 1ns/10ps
module conv_ctrl_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic select_n,
  input wire logic read_convert,
  input wire logic clock_source_select,
  input wire logic busy_n,
  input wire logic parallel_bus_oe,
  input wire logic serial_result_out,
  input wire logic shift_clock,
  input wire logic shift_clock_oe
);
  logic both_low;
  assign both_low = !select_n && !read_convert;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic       sclk_d_r;
  logic [4:0] pulses_r;
  // rising pulses counted while busy is low, cleared while it is high
  always_ff @(posedge aclk) begin
    sclk_d_r <= shift_clock;
    if (!aresetn || busy_n) pulses_r <= 5'h00;
    else if (shift_clock && !sclk_d_r) pulses_r <= pulses_r + 5'h01;
  end
  chk_busy_hold: assert property ($fell(busy_n) |=> !busy_n [*8])
    else $error("busy short");
  chk_busy_end: assert property ($fell(busy_n) |-> ##[20:1000] $rose(busy_n))
    else $error("busy stuck");
  chk_start_cause: assert property ($fell(busy_n) |-> $past(both_low, 3) ||
    $past(both_low, 4) || $past(both_low, 5) || $past(both_low, 6)) else $error("no cause");
  chk_bus_off_cs: assert property (select_n [*4] |-> !parallel_bus_oe)
    else $error("bus driven");
  chk_bus_off_conv: assert property (!read_convert [*4] |-> !parallel_bus_oe)
    else $error("bus driven in convert");
  chk_bus_on_read: assert property ((!select_n && read_convert) [*5] |-> parallel_bus_oe)
    else $error("bus not driven");
  chk_sclk_dir: assert property ($stable(clock_source_select) [*8] |->
    shift_clock_oe == !clock_source_select) else $error("shift clock direction");
  chk_sclk_idle: assert property (busy_n [*2] |-> !shift_clock)
    else $error("pulse outside busy");
  chk_bit_hold: assert property (shift_clock |-> $stable(serial_result_out))
    else $error("bit moved");
  chk_bit_fall: assert property ($fell(shift_clock) |-> $stable(serial_result_out))
    else $error("bit moved at fall");
  chk_pulse_count: assert property ($rose(busy_n) && shift_clock_oe |-> pulses_r == 5'h10)
    else $error("pulse count");
endmodule // conv_ctrl_sva
bind sar_adc_conversion_control conv_ctrl_sva u_sva (.aclk(aclk), .aresetn(aresetn),
  .select_n(select_n), .read_convert(read_convert), .clock_source_select(clock_source_select),
  .busy_n(busy_n), .parallel_bus_oe(parallel_bus_oe), .serial_result_out(serial_result_out),
  .shift_clock(shift_clock), .shift_clock_oe(shift_clock_oe));

// [verif/host_model.sv]
// partner: host pulsing convert and capturing serial words
`timescale 1ns/10ps
module host_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        go,
  input  wire logic        cs_on,
  input  wire logic        shift_clock,
  input  wire logic        serial_result_out,
  output logic             select_n,
  output logic             read_convert,
  output logic [15:0]      rx_word,
  output logic [4:0]       rx_count
);
  logic [2:0] cnt_r;
  logic       sclk_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_r <= 3'h0;
    else if (go && cnt_r == 3'h0) cnt_r <= 3'h6;
    else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
  end
  // select leads so the convert input initiates
  assign select_n = !(cs_on || cnt_r != 3'h0);
  // low 100 ns, raised well before busy returns to avoid a bad restart
  assign read_convert = !(cnt_r inside {[3'h1:3'h4]});
  always_ff @(posedge aclk) begin
    sclk_r <= shift_clock;
    if (!aresetn || go) begin
      rx_word  <= 16'h0000;
      rx_count <= 5'h00;
    end else if (shift_clock && !sclk_r) begin
      rx_word  <= {rx_word[14:0], serial_result_out};
      rx_count <= rx_count + 5'h01;
    end
  end
endmodule // host_model

// [verif/testbench.sv]
// testbench: convert, parallel read and serial result checks
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
  import conv_ctrl_pkg::*;
  logic        aclk, aresetn, select_n, read_convert, half_select, clock_source_select, go;
  logic        format_select, busy_n, parallel_bus_oe, serial_result_out, shift_clock, cs_on;
  logic        shift_clock_oe, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [4:0]  rx_count;
  logic [7:0]  parallel_bus;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [15:0] rx_word;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          fail_count, checked, n, idle_cyc;
  localparam int CMD_GAP_CYC = 1000; // 25 us of a 25 ns clock
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) idle_cyc <= go ? 0 : idle_cyc + 1;
  sar_adc_conversion_control #(.conv_cycles(40), .shift_half(SHIFT_HALF_CYC)) dut (
    .aclk, .aresetn, .select_n, .read_convert, .half_select, .clock_source_select,
    .format_select, .busy_n, .parallel_bus, .parallel_bus_oe, .serial_result_out,
    .shift_clock, .shift_clock_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  host_model host (.aclk, .aresetn, .go, .cs_on, .shift_clock, .serial_result_out,
    .select_n, .read_convert, .rx_word, .rx_count);
  task automatic give_verdict();
    $display("checked %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic bound(input int lim);
    if (n >= lim) begin
      fail_count++;
      $display("unexpected at %0t: wait timed out", $time);
      give_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] r = RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 99);
    `CHK(s_axi_bresp, r)
    s_axi_bready <= 1'h0;
    bound(99);
  endtask
  task automatic rd(input logic [11:0] a, input logic [17:0] e);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 99);
    `CHK({s_axi_rresp, s_axi_rdata[15:0]}, e)
    s_axi_rready <= 1'h0;
    bound(99);
  endtask
  task automatic wait_busy(input logic v);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      go <= 1'h0;
    end while (busy_n !== v && n < 600);
    bound(600);
  endtask
  task automatic launch();
    n = 0;
    while (idle_cyc < CMD_GAP_CYC && n < 1100) begin
      @(posedge aclk);
      n++;
    end
    bound(1100);
    go <= 1'h1;
  endtask
  task automatic bytes(input logic [15:0] e);
    cs_on <= 1'h1;
    half_select <= 1'h0;
    repeat (6) @(posedge aclk);
    `CHK({parallel_bus_oe, parallel_bus}, {1'h1, e[15:8]})
    half_select <= 1'h1;
    repeat (6) @(posedge aclk);
    `CHK(parallel_bus, e[7:0])
  endtask
  initial begin
    {aclk, aresetn, go, cs_on, half_select, format_select} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    clock_source_select = 1'h1;
    s_axi_wstrb = 4'hF;
    fail_count = 0;
    checked = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    `CHK({busy_n, parallel_bus_oe, shift_clock}, 3'h4)
    rd(12'hFFC, {RESP_SLVERR, 16'h0000});
    wr(12'hFFC, 16'h0000, RESP_SLVERR);
    $display("test reset done");
    wr(ADDR_SAMPLE, 16'hA5C3);
    launch();
    wait_busy(1'h0);
    wait_busy(1'h1);
    rd(ADDR_RESULT, {RESP_OKAY, 16'hA5C3});
    rd(ADDR_STATUS, {RESP_OKAY, 16'h0001});
    bytes(16'hA5C3);
    cs_on <= 1'h0;
    repeat (6) @(posedge aclk);
    `CHK(parallel_bus_oe, 1'h0)
    format_select <= 1'h1;
    wr(ADDR_SAMPLE, 16'h1234);
    launch();
    wait_busy(1'h0);
    go <= 1'h1;
    @(posedge aclk);
    go <= 1'h0;
    repeat (8) @(posedge aclk);
    bytes(16'hA5C3);
    wait_busy(1'h1);
    repeat (10) @(posedge aclk);
    `CHK(busy_n, 1'h1)
    bytes(16'h9234);
    $display("test parallel done");
    {cs_on, format_select, clock_source_select} <= 3'h0;
    wr(ADDR_SAMPLE, 16'h5A0F);
    launch();
    wait_busy(1'h0);
    wait_busy(1'h1);
    `CHK({shift_clock_oe, rx_count, rx_word}, {1'h1, 5'h10, 16'h9234})
    cs_on <= 1'h1;
    launch();
    wait_busy(1'h0);
    wait_busy(1'h1);
    `CHK(rx_word, 16'h5A0F)
    $display("test serial done");
    give_verdict();
  end
endmodule // testbench
